// file: verilog/vst_pkg.sv
`default_nettype none
package vst_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int PORT_NUM = 4;
  localparam int PORT_W = 2;
  localparam int CNT_W = 14;
  localparam int ADDR_W = 8;

  // ***************************************************************
  // Values after reset and size limits
  // ***************************************************************
  localparam logic [15:0] TPID_RST = 16'h8100;
  localparam logic [13:0] MRU_RST = 14'h0000;
  localparam logic [13:0] MRU_GIG = 14'h2800;
  localparam logic [13:0] MRU_FAST = 14'h25EE;
  localparam logic [11:0] SVID_RST = 12'h001;
  localparam logic [15:0] DROP_RST = 16'h0000;

  // ***************************************************************
  // Register offsets and field positions
  // ***************************************************************
  localparam logic [ADDR_W-1:0] OFS_TPID = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DROP = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MRU = 8'h20;
  localparam int CFG_ROLE_BIT = 0;
  localparam int CFG_GIG_BIT = 1;
  localparam int CFG_SVID_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***************************************************************
  // Byte positions within a frame
  // ***************************************************************
  localparam logic [CNT_W-1:0] POS_FIRST = 14'h0000;
  localparam logic [CNT_W-1:0] POS_HDR_LAST = 14'h000B;
  localparam logic [CNT_W-1:0] POS_ETY_HI = 14'h000C;
  localparam logic [CNT_W-1:0] POS_ETY_LO = 14'h000D;
  localparam logic [CNT_W-1:0] POS_VID_HI = 14'h000E;
  localparam logic [CNT_W-1:0] POS_VID_LO = 14'h000F;
  localparam logic [CNT_W-1:0] POS_MAX = 14'h3FFF;
  localparam logic [1:0] INS_FIRST = 2'h0;
  localparam logic [1:0] INS_LAST = 2'h3;

  typedef enum logic [1:0] {
    VST_OP_PASS = 2'b00,
    VST_OP_PUSH = 2'b01,
    VST_OP_POP = 2'b10
  } vst_op_t;

  typedef enum logic [0:0] {
    VST_ST_RUN = 1'b0,
    VST_ST_INS = 1'b1
  } vst_state_t;

endpackage
`default_nettype wire

// file: verilog/vst_axil.sv
`timescale 1ns/1ps
`default_nettype none
module vst_axil
  import vst_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_stb,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  // Address and data are latched on their own handshakes; the write
  // is strobed in the first cycle in which both are held.
  logic aw_take;
  logic w_take;
  logic b_done;
  logic ar_take;
  logic r_done;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign b_done = s_axi_bvalid & s_axi_bready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign r_done = s_axi_rvalid & s_axi_rready;
  assign wr_stb = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (aw_take) begin
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_stb) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_data : 32'h00000000;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (r_done) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: verilog/vst_tagger.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Edge-to-provider frames get a provider tag inserted after source address.
// - Inserted tag is TPID then TCI with 12-bit provider VLAN id.
// - Untagged edge frames leave carrying only that inserted tag.
// - Forwarding id reported is the outer tag id; inner tag ignored.
// - Provider-to-edge frames lose outer tag; customer tag stays intact.
// - After popping, frame leaves as is, no egress tagging change.
// - Outer ethertype comes from TPID register, 0x8100 after reset.
// - One TPID register serves every stacking VLAN.
// - Provider port refuses frames whose first ethertype is not the TPID.
// - Edge ports take tagged and untagged frames alike.
// - Each edge port holds exactly one provider VLAN id.
// - Provider ports pass frames of any outer VLAN id.
// - A single role bit makes each port edge or provider, never both.
// - Several edge ports may share one provider VLAN id.
// - Receive limit per port is a 14-bit register, well above 1522.
// - Limit defaults to 10240 bytes on gigabit ports.
// - Limit defaults to 9710 bytes on 100 Mbps ports.
module vst_tagger
  import vst_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  input wire logic [PORT_W-1:0] in_src,
  input wire logic [PORT_W-1:0] in_dst,
  output logic in_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  output logic out_err,
  output logic [11:0] out_vid
);

  // ***************************************************************
  // Register file
  // ***************************************************************
  logic wr_stb;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [15:0] tpid_reg;
  logic [15:0] drop_cnt_reg;
  logic role_reg [PORT_NUM];
  logic gig_reg [PORT_NUM];
  logic [11:0] svid_reg [PORT_NUM];
  logic [13:0] mru_reg [PORT_NUM];

  vst_axil u_axil (
    .mclk(mclk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  logic w_tpid_hit;
  logic w_cfg_hit;
  logic w_mru_hit;
  logic w_drop_hit;
  logic r_tpid_hit;
  logic r_cfg_hit;
  logic r_mru_hit;
  logic r_drop_hit;
  logic [PORT_W-1:0] w_idx;
  logic [PORT_W-1:0] r_idx;
  logic [31:0] rd_cfg_word;

  assign w_idx = wr_addr[3:2];
  assign r_idx = rd_addr[3:2];
  assign w_tpid_hit = wr_addr[7:2] == OFS_TPID[7:2];
  assign w_drop_hit = wr_addr[7:2] == OFS_DROP[7:2];
  assign w_cfg_hit = wr_addr[7:4] == OFS_CFG[7:4];
  assign w_mru_hit = wr_addr[7:4] == OFS_MRU[7:4];
  assign r_tpid_hit = rd_addr[7:2] == OFS_TPID[7:2];
  assign r_drop_hit = rd_addr[7:2] == OFS_DROP[7:2];
  assign r_cfg_hit = rd_addr[7:4] == OFS_CFG[7:4];
  assign r_mru_hit = rd_addr[7:4] == OFS_MRU[7:4];
  assign wr_ok = w_tpid_hit | w_drop_hit | w_cfg_hit | w_mru_hit;
  assign rd_ok = r_tpid_hit | r_drop_hit | r_cfg_hit | r_mru_hit;
  assign rd_cfg_word = {4'h0, svid_reg[r_idx], 14'h0000,
                        gig_reg[r_idx], role_reg[r_idx]};
  assign rd_data = r_tpid_hit ? {16'h0000, tpid_reg} :
                   r_drop_hit ? {16'h0000, drop_cnt_reg} :
                   r_cfg_hit ? rd_cfg_word :
                   r_mru_hit ? {18'h00000, mru_reg[r_idx]} : 32'h00000000;

  // A single global TPID serves every stacking VLAN.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tpid_reg <= TPID_RST;
    end else if (wr_stb && w_tpid_hit) begin
      if (wr_strb[0]) tpid_reg[7:0] <= wr_data[7:0];
      if (wr_strb[1]) tpid_reg[15:8] <= wr_data[15:8];
    end
  end

  for (genvar p = 0; p < PORT_NUM; p++) begin : g_port
    logic cfg_wr;
    logic mru_wr;
    assign cfg_wr = wr_stb && w_cfg_hit && w_idx == PORT_W'(p);
    assign mru_wr = wr_stb && w_mru_hit && w_idx == PORT_W'(p);
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        role_reg[p] <= 1'b0;
        gig_reg[p] <= 1'b1;
        svid_reg[p] <= SVID_RST;
        mru_reg[p] <= MRU_RST;
      end else begin
        if (cfg_wr && wr_strb[0]) begin
          role_reg[p] <= wr_data[CFG_ROLE_BIT];
          gig_reg[p] <= wr_data[CFG_GIG_BIT];
        end
        if (cfg_wr && wr_strb[2]) begin
          svid_reg[p][7:0] <= wr_data[CFG_SVID_LSB+:8];
        end
        if (cfg_wr && wr_strb[3]) begin
          svid_reg[p][11:8] <= wr_data[CFG_SVID_LSB+8+:4];
        end
        if (mru_wr && wr_strb[0]) mru_reg[p][7:0] <= wr_data[7:0];
        if (mru_wr && wr_strb[1]) mru_reg[p][13:8] <= wr_data[13:8];
      end
    end
  end

  // ***************************************************************
  // Frame path
  // ***************************************************************
  logic [CNT_W-1:0] cnt_reg;
  logic [PORT_W-1:0] src_reg;
  vst_op_t op_reg;
  vst_state_t state_reg;
  vst_state_t state_next;
  logic [1:0] ins_cnt_reg;
  logic [7:0] ety_hi_reg;
  logic [11:0] ovid_reg;
  logic err_reg;
  logic acc;
  logic first;
  logic [PORT_W-1:0] src_w;
  logic [PORT_W-1:0] dst_w;
  vst_op_t op_w;
  vst_op_t cur_op;
  logic in_tag;
  logic skip;
  logic emit;
  logic [13:0] lim_auto;
  logic [13:0] lim_cur;
  logic len_bad;
  logic untag_bad;
  logic bad_now;
  logic start_ins;
  logic [11:0] svid_sel;
  logic [31:0] tag_word;
  logic [7:0] tag_byte;
  logic [11:0] vid_w;
  logic [CNT_W-1:0] cnt_inc;

  assign acc = in_valid & in_ready;
  assign first = cnt_reg == POS_FIRST;
  assign src_w = first ? in_src : src_reg;
  assign dst_w = in_dst;
  // Edge to edge needs no change: a push and a pop cancel out.
  assign op_w = (!role_reg[src_w] && role_reg[dst_w]) ? VST_OP_PUSH :
                (role_reg[src_w] && !role_reg[dst_w]) ? VST_OP_POP :
                VST_OP_PASS;
  assign cur_op = first ? op_w : op_reg;
  assign in_tag = cnt_reg >= POS_ETY_HI && cnt_reg <= POS_VID_LO;
  assign skip = cur_op == VST_OP_POP && in_tag;
  // A frame ending inside the tag still needs a last byte; it is dropped.
  assign emit = acc && (!skip || in_last);
  assign lim_auto = gig_reg[src_w] ? MRU_GIG : MRU_FAST;
  assign lim_cur = mru_reg[src_w] == MRU_RST ? lim_auto : mru_reg[src_w];
  assign len_bad = cnt_reg >= lim_cur;
  assign untag_bad = role_reg[src_w] && cnt_reg == POS_ETY_LO &&
                     {ety_hi_reg, in_data} != tpid_reg;
  assign bad_now = err_reg | len_bad | untag_bad | (skip & in_last);
  assign start_ins = acc && cnt_reg == POS_HDR_LAST &&
                     cur_op == VST_OP_PUSH && !in_last;
  assign svid_sel = svid_reg[src_reg];
  assign tag_word = {tpid_reg, 4'h0, svid_sel};
  assign tag_byte = ins_cnt_reg == 2'h0 ? tag_word[31:24] :
                    ins_cnt_reg == 2'h1 ? tag_word[23:16] :
                    ins_cnt_reg == 2'h2 ? tag_word[15:8] : tag_word[7:0];
  assign vid_w = role_reg[src_w] ? ovid_reg : svid_reg[src_w];
  assign cnt_inc = cnt_reg == POS_MAX ? cnt_reg : CNT_W'(cnt_reg + 1'b1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      VST_ST_RUN: begin
        if (start_ins) state_next = VST_ST_INS;
      end
      VST_ST_INS: begin
        if (ins_cnt_reg == INS_LAST) state_next = VST_ST_RUN;
      end
      default: state_next = VST_ST_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= VST_ST_RUN;
      ins_cnt_reg <= INS_FIRST;
      in_ready <= 1'b1;
    end else begin
      state_reg <= state_next;
      in_ready <= state_next == VST_ST_RUN;
      ins_cnt_reg <= state_reg == VST_ST_INS ? 2'(ins_cnt_reg + 1'b1) :
                     INS_FIRST;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= POS_FIRST;
      src_reg <= '0;
      op_reg <= VST_OP_PASS;
      ety_hi_reg <= 8'h00;
      ovid_reg <= 12'h000;
      err_reg <= 1'b0;
    end else if (acc) begin
      cnt_reg <= in_last ? POS_FIRST : cnt_inc;
      err_reg <= in_last ? 1'b0 : bad_now;
      if (first) begin
        src_reg <= in_src;
        op_reg <= op_w;
      end
      if (cnt_reg == POS_ETY_HI) ety_hi_reg <= in_data;
      if (cnt_reg == POS_VID_HI) ovid_reg[11:8] <= in_data[3:0];
      if (cnt_reg == POS_VID_LO) ovid_reg[7:0] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= 8'h00;
      out_last <= 1'b0;
      out_err <= 1'b0;
      out_vid <= 12'h000;
    end else if (state_reg == VST_ST_INS) begin
      out_valid <= 1'b1;
      out_data <= tag_byte;
      out_last <= 1'b0;
      out_err <= 1'b0;
    end else if (emit) begin
      out_valid <= 1'b1;
      out_data <= in_data;
      out_last <= in_last;
      out_err <= in_last & bad_now;
      if (in_last) out_vid <= vid_w;
    end else begin
      out_valid <= 1'b0;
      out_last <= 1'b0;
      out_err <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drop_cnt_reg <= DROP_RST;
    end else if (out_valid && out_last && out_err) begin
      drop_cnt_reg <= 16'(drop_cnt_reg + 1'b1);
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_ins_stall: assert property (state_reg == VST_ST_INS |-> !in_ready)
    else $error("input not stalled during tag insertion");
  a_push_tpid: assert property (start_ins |-> ##2 (out_valid &&
      out_data == tpid_reg[15:8]) ##1 (out_data == tpid_reg[7:0]))
    else $error("inserted tag does not start with the TPID");
  a_push_vid: assert property (start_ins |-> ##4
      (out_data == {4'h0, svid_sel[11:8]}) ##1 (out_data == svid_sel[7:0]))
    else $error("inserted tag does not carry the port VLAN id");
  a_ins_four: assert property ($rose(state_reg == VST_ST_INS) |->
      (state_reg == VST_ST_INS)[*4] ##1 in_ready)
    else $error("tag insertion is not exactly four bytes");
  a_pop_skip: assert property (acc && skip && !in_last |=> !out_valid)
    else $error("outer tag byte leaked on pop");
  a_pass_data: assert property (emit && state_reg == VST_ST_RUN |=>
      out_valid && out_data == $past(in_data))
    else $error("frame byte not passed unchanged");
  a_untag_drop: assert property (acc && untag_bad |=>
      err_reg || (out_last && out_err))
    else $error("untagged frame on provider port not refused");
  a_len_drop: assert property (acc && in_last && len_bad |=>
      out_valid && out_last && out_err)
    else $error("oversize frame not marked for discard");
  a_drop_count: assert property (out_valid && out_last && out_err |=>
      drop_cnt_reg == 16'($past(drop_cnt_reg) + 1'b1))
    else $error("discard counter did not advance");

  c_push: cover property (start_ins ##5 state_reg == VST_ST_RUN);
  c_pop: cover property (acc && skip ##4 out_valid);
  c_drop: cover property (out_valid && out_last && out_err);

endmodule
`default_nettype wire

// file: verification/vst_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************************************************
// Far-end port model
// ********************************************************************
module vst_far_end (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_err,
  input wire logic [11:0] out_vid,
  output logic got,
  output logic [21:0] got_word
);
  // The far side has no way to stall, so every byte is captured as it passes.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      got <= 1'b0;
      got_word <= 22'h0;
    end else begin
      got <= out_valid;
      got_word <= {out_last, out_err, out_vid, out_data};
    end
  end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import vst_pkg::*;
();
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] aw_a, ar_a;
  logic aw_v, w_v, b_r, ar_v, r_r, aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic [31:0] w_d, r_d;
  logic [1:0] b_resp, r_resp;
  logic i_v, i_l, i_rdy, o_v, o_l, o_e, got;
  logic [7:0] i_d, o_d;
  logic [PORT_W-1:0] i_s, i_t;
  logic [11:0] o_vid;
  logic [21:0] gw;
  logic [22:0] exq[$];
  logic [11:0] vidp[PORT_NUM];
  logic role[PORT_NUM];
  logic [15:0] tpid;
  logic [3:0] w_s = 4'hF;
  int err_count = 0;
  int n_tests = 0;

  always #2 mclk = ~mclk;

  vst_tagger dut_u (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(aw_a),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d),
    .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
    .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_r), .in_valid(i_v), .in_data(i_d), .in_last(i_l),
    .in_src(i_s), .in_dst(i_t), .in_ready(i_rdy), .out_valid(o_v),
    .out_data(o_d), .out_last(o_l), .out_err(o_e), .out_vid(o_vid));

  vst_far_end far_u (.mclk(mclk), .rst_n(rst_n), .out_valid(o_v),
    .out_data(o_d), .out_last(o_l), .out_err(o_e), .out_vid(o_vid),
    .got(got), .got_word(gw));

  // ******************************************************************
  // Checking
  // ******************************************************************
  task automatic stop_test;
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask

  // Error flag and forwarding id only mean something on the last byte.
  always @(negedge mclk) begin
    logic [22:0] e;
    logic [21:0] m;
    if (got === 1'b1) begin
      e = (exq.size() > 0) ? exq.pop_front() : 23'h7FFFFF;
      m = !e[21] ? 22'h2000FF : (!e[22] ? 22'h3000FF : 22'h3FFFFF);
      chk("out_byte", {10'h0, e[21:0] & m}, {10'h0, gw & m});
    end
  end

  initial begin
    #240000;
    err_count++;
    stop_test;
  end

  // ******************************************************************
  // Register bus
  // ******************************************************************
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    logic sa, sw, hb;
    logic [1:0] eb;
    hb = 1'b0;
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    while (!hb) begin
      @(negedge mclk);
      sa = aw_v & aw_rdy;
      sw = w_v & w_rdy;
      hb = b_v;
      eb = b_resp;
      @(posedge mclk);
      if (sa) aw_v <= 1'b0;
      if (sw) w_v <= 1'b0;
    end
    chk("bresp", {30'h0, er}, {30'h0, eb});
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    logic sa, hr;
    logic [31:0] gd;
    logic [1:0] ge;
    hr = 1'b0;
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    while (!hr) begin
      @(negedge mclk);
      sa = ar_v & ar_rdy;
      hr = r_v;
      gd = r_d;
      ge = r_resp;
      @(posedge mclk);
      if (sa) ar_v <= 1'b0;
    end
    chk("rresp", {30'h0, er}, {30'h0, ge});
    chk("rdata", ed, gd);
  endtask

  task automatic cfgp(int p, logic r, logic g, logic [11:0] v);
    wr(OFS_CFG + 8'(4 * p), {4'h0, v, 14'h0, g, r}, RESP_OKAY);
    role[p] = r;
    vidp[p] = v;
  endtask

  // ******************************************************************
  // Frame traffic
  // ******************************************************************
  task automatic send(int s, int t, int n, logic [31:0] h, logic ee,
                      logic cv);
    logic [7:0] f[$];
    logic push, pop, ok;
    logic [11:0] v;
    f = {};
    for (int i = 0; i < n; i++) f.push_back(8'($urandom));
    for (int i = 0; i < 4; i++) f[12 + i] = h[31 - 8 * i -: 8];
    push = !role[s] && role[t];
    pop = role[s] && !role[t];
    v = role[s] ? {f[14][3:0], f[15]} : vidp[s];
    for (int i = 0; i < n; i++) begin
      if (!(pop && i >= 12 && i <= 15))
        exq.push_back({cv, i == n - 1, ee, v, f[i]});
      if (push && i == 11) begin
        exq.push_back({3'h0, v, tpid[15:8]});
        exq.push_back({3'h0, v, tpid[7:0]});
        exq.push_back({3'h0, v, 4'h0, v[11:8]});
        exq.push_back({3'h0, v, v[7:0]});
      end
    end
    for (int i = 0; i < n; i++) begin
      i_v <= 1'b1;
      i_d <= f[i];
      i_l <= (i == n - 1);
      i_s <= PORT_W'(s);
      i_t <= PORT_W'(t);
      do begin
        @(negedge mclk);
        ok = i_rdy;
        @(posedge mclk);
      end while (ok !== 1'b1);
    end
    i_v <= 1'b0;
    i_l <= 1'b0;
    @(posedge mclk);
  endtask

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    {aw_a, ar_a, aw_v, w_v, b_r, ar_v, r_r, w_d} = '0;
    {i_v, i_l, i_d, i_s, i_t} = '0;
    tpid = TPID_RST;
    for (int p = 0; p < PORT_NUM; p++) begin
      role[p] = 1'b0;
      vidp[p] = SVID_RST;
    end
    void'($urandom(7098));
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(OFS_TPID, 32'h00008100, RESP_OKAY);
    rd(OFS_CFG, 32'h00010002, RESP_OKAY);
    rd(8'h08, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    cfgp(0, 1'b0, 1'b1, 12'h123);
    cfgp(1, 1'b1, 1'b1, 12'h000);
    cfgp(2, 1'b0, 1'b1, 12'h123);
    cfgp(3, 1'b0, 1'b0, 12'h456);
    wr(OFS_TPID, 32'h000088A8, RESP_OKAY);
    tpid = 16'h88A8;
    rd(OFS_TPID, 32'h000088A8, RESP_OKAY);
    w_s <= 4'h1;
    wr(OFS_TPID, 32'h00001234, RESP_OKAY);
    w_s <= 4'hF;
    rd(OFS_TPID, 32'h00008834, RESP_OKAY);
    wr(OFS_TPID, 32'h000088A8, RESP_OKAY);
    wr(OFS_DROP, 32'h5, RESP_OKAY);
    send(0, 1, 20, 32'h08001234, 1'b0, 1'b1);
    send(3, 1, 24, 32'h81000ABC, 1'b0, 1'b1);
    send(2, 1, 18, 32'h81000007, 1'b0, 1'b1);
    send(1, 0, 26, 32'h88A807FF, 1'b0, 1'b1);
    send(1, 3, 22, 32'h88A80ABC, 1'b0, 1'b1);
    send(1, 1, 20, 32'h08000000, 1'b1, 1'b0);
    send(0, 2, 20, 32'h81000005, 1'b0, 1'b1);
    wr(OFS_MRU, 32'd20, RESP_OKAY);
    rd(OFS_MRU, 32'd20, RESP_OKAY);
    send(0, 2, 20, 32'h08000000, 1'b0, 1'b1);
    send(0, 2, 21, 32'h08000000, 1'b1, 1'b1);
    send(3, 0, 9711, 32'h08000000, 1'b1, 1'b1);
    send(2, 0, 10240, 32'h08000000, 1'b0, 1'b1);
    send(2, 0, 10241, 32'h08000000, 1'b1, 1'b1);
    repeat (20) @(posedge mclk);
    rd(OFS_DROP, 32'd4, RESP_OKAY);
    chk("queue_left", 32'h0, 32'(exq.size()));
    stop_test;
  end
endmodule
`default_nettype wire
